// [logic/ccu_pkg.sv]
// Constants, register map and types of the clock control unit
package ccu_pkg;
  localparam logic [11:0] OFS_DIV = 12'h000;
  localparam logic [11:0] OFS_PLL = 12'h004;
  localparam logic [11:0] OFS_TUN = 12'h008;
  localparam logic [11:0] OFS_OSC = 12'h00c;

  localparam logic [15:0] DIV_RST  = 16'h3040;
  localparam logic [15:0] PLL_RST  = 16'h0030;
  localparam logic [15:0] TUN_RST  = 16'h0000;
  localparam logic [15:0] DIV_MASK = 16'hffdf;
  localparam logic [15:0] PLL_MASK = 16'h01ff;
  localparam logic [15:0] TUN_MASK = 16'h003f;

  localparam int ROI_B     = 15;
  localparam int DOZE_LSB  = 12;
  localparam int CPU_SLOWDOWN_ENABLE_B   = 11;
  localparam int FRCD_LSB  = 8;
  localparam int POST_LSB  = 6;
  localparam int PRE_LSB   = 0;
  localparam int CURRENT_SOURCE_STATUS_LSB  = 12;
  localparam int NEXT_SOURCE_SELECT_LSB  = 8;
  localparam int LKOUT_B   = 7;
  localparam int LOCK_B    = 5;
  localparam int CF_B      = 3;
  localparam int SEC_B     = 1;
  localparam int REQ_B     = 0;

  localparam logic [2:0] SRC_FRC    = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_WITH_MULTIPLIER = 3'h1;
  localparam logic [2:0] SRC_PRI    = 3'h2;
  localparam logic [2:0] SRC_PRIPLL = 3'h3;
  localparam logic [2:0] SRC_SEC    = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC   = 3'h5;
  localparam logic [2:0] SRC_FRC16  = 3'h6;
  localparam logic [2:0] SRC_FRCN   = 3'h7;

  localparam logic [1:0] PSM_EC     = 2'h0;
  localparam logic [3:0] SETTLE_CYC = 4'ha;
  localparam logic [1:0] CAP_CYC    = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SETTLE} ccu_state_t;
endpackage

// [logic/ccu_sync.sv]
// Two-flop synchroniser for pins and foreign-clock levels
`timescale 1ns/1ps
module ccu_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // ccu_sync

// [logic/ccu_top.sv]
// Clock divisor, PLL, trim registers and clock switch control over APB
//
// Notes on behaviour
// (RL1) With recover set, an interrupt clears slowdown enable; otherwise no effect.
// (RL2) Processor reduction code divides by two to the code, reset code 011.
// (RL3) Slowdown enable applies the reduction; clear forces ratio 1:1.
// (RL4) Fast RC postscaler divides by two to the code, code 111 by 256.
// (RL5) PLL output divider: 00 by 2, 01 by 4 (reset), 11 by 8.
// (RL6) PLL input divider is field plus two, reset value 00000.
// (RL7) PLL multiplier is field plus two, reset factor 50.
// (RL8) Fast RC trim is a six-bit two's complement frequency offset.
// (RL9) Switching and fail monitor work only when the config bit is 0.
// (RL10) Switching off: next select ignored, current shows reset source, request 0.
// (RL11) Software writes next select, then sets the switch request.
// (RL12) Request to the source already in use is cleared and aborted.
// (RL13) A valid switch start clears PLL lock and clock fail flags.
// (RL14) New source is started; wait crystal timer or PLL lock.
// (RL15) After ready, count 10 new clock cycles before switching over.
// (RL16) Switch done clears request and copies next select to current.
// (RL17) Old source stops, except low-power RC and secondary when still needed.
// (RL18) The processor keeps running throughout the switch.
// (RL19) No direct switch between primary PLL and fast RC PLL modes; the code does not block such a switch.
// (RL20) Primary submode is fixed from the configuration and never changes.
// (RL21) With fail monitor on, low-power RC runs always except in sleep.
// (RL22) On failure trap and fall back to fast RC, via PLL if used.
// (RL23) Three-bit source codes 000 to 111 select the eight clock modes.
// (RL24) Lockout bit, when allowed, blocks every later clock switch.
// (RL25) Register defaults load on reset before any switch is accepted.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ccu_top
  import ccu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_event,
  input  wire logic        watchdog_enable,
  input  wire logic        sleep_active,
  input  wire logic        switch_monitor_config,
  input  wire logic        fail_monitor_off_config,
  input  wire logic [2:0]  reset_source_config,
  input  wire logic [1:0]  primary_submode_config,
  input  wire logic        crystal_timer_done,
  input  wire logic        pll_lock,
  input  wire logic        osc_fail,
  input  wire logic        new_clk,
  output logic      [2:0]  cpu_div_log2,
  output logic      [3:0]  frc_div_log2,
  output logic      [5:0]  pll_n1,
  output logic      [3:0]  pll_n2,
  output logic      [9:0]  pll_m,
  output logic      [5:0]  frc_trim,
  output logic      [2:0]  sys_src_sel,
  output logic      [1:0]  primary_submode,
  output logic             frc_on,
  output logic             pri_on,
  output logic             sec_on,
  output logic             low_power_rc_osc_on,
  output logic             pll_on,
  output logic             clock_fail_trap,
  output logic             switch_busy
);
  logic [10:0] sync_q;
  logic        smc_s;
  logic        fmoff_s;
  logic [2:0]  rsc_s;
  logic [1:0]  psm_s;
  logic        xtal_s;
  logic        lock_s;
  logic        fail_s;
  logic        nclk_s;
  logic        nclk_d;
  logic        tick;
  logic [1:0]  cap_cnt;
  logic        cap_now;
  logic        cfg_taken;
  logic        smc_q;
  logic        fmoff_q;
  logic [2:0]  strap_src;
  logic        sw_en;
  logic        clock_fail_monitor_on;
  logic [15:0] div_q;
  logic [15:0] pll_q;
  logic [15:0] tun_q;
  logic [2:0]  next_source_select;
  logic [2:0]  tgt;
  logic [2:0]  cur;
  logic        req;
  logic        cf;
  logic        lock_stat;
  logic        lockout;
  logic        sec_en;
  logic [3:0]  cnt;
  ccu_state_t  st;
  logic        setup;
  logic        wr;
  logic        div_wr;
  logic        pll_wr;
  logic        tun_wr;
  logic        osc_wr;
  logic        src_ready;
  logic        fail_go;
  logic        busy;
  logic [15:0] osc_rd;

  function automatic logic is_pll(input logic [2:0] s);
    return (s == SRC_FAST_RC_WITH_MULTIPLIER) || (s == SRC_PRIPLL);
  endfunction

  function automatic logic is_pri(input logic [2:0] s);
    return (s == SRC_PRI) || (s == SRC_PRIPLL);
  endfunction

  // Fast RC feeds every mode that is not primary, secondary or low-power RC
  function automatic logic is_frc(input logic [2:0] s);
    return !is_pri(s) && (s != SRC_SEC) && (s != SRC_LOW_POWER_RC_OSC);
  endfunction

  function automatic logic [3:0] post_div(input logic [1:0] c);
    unique case (c)
      2'h0: return 4'h2;
      2'h1: return 4'h4;
      2'h3: return 4'h8;
      default: return 4'h4;
    endcase
  endfunction

  ccu_sync #(.W(11)) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({new_clk, osc_fail, pll_lock, crystal_timer_done,
                primary_submode_config, reset_source_config,
                fail_monitor_off_config, switch_monitor_config}),
    .sync_out (sync_q)
  );

  assign smc_s   = sync_q[0];
  assign fmoff_s = sync_q[1];
  assign rsc_s   = sync_q[4:2];
  assign psm_s   = sync_q[6:5];
  assign xtal_s  = sync_q[7];
  assign lock_s  = sync_q[8];
  assign fail_s  = sync_q[9];
  assign nclk_s  = sync_q[10];
  assign tick    = nclk_s & ~nclk_d;

  // Straps are caught once the synchroniser has filled after release
  assign cap_now   = (cap_cnt == CAP_CYC - 2'h1);
  assign cfg_taken = (cap_cnt == CAP_CYC);
  assign sw_en     = cfg_taken & ~smc_q;                 // [RL9]
  assign clock_fail_monitor_on   = sw_en & ~fmoff_q;                   // [RL9]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cap_cnt         <= 2'h0;
      smc_q           <= 1'b1;
      fmoff_q         <= 1'b1;
      strap_src       <= SRC_FRC;
      primary_submode <= PSM_EC;
    end else if (!cfg_taken) begin
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_now) begin
        smc_q           <= smc_s;
        fmoff_q         <= fmoff_s;
        strap_src       <= rsc_s;
        primary_submode <= psm_s;                        // [RL20]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nclk_d <= 1'b0;
    end else begin
      nclk_d <= nclk_s;
    end
  end

  // Zero-wait APB slave; read data and error are prepared in the setup cycle
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite;
  assign div_wr = wr & (paddr == OFS_DIV);
  assign pll_wr = wr & (paddr == OFS_PLL);
  assign tun_wr = wr & (paddr == OFS_TUN);
  assign osc_wr = wr & (paddr == OFS_OSC);

  assign osc_rd = {1'b0, cur, 1'b0, next_source_select, lockout, 1'b0, lock_stat,
                   1'b0, cf, 1'b0, sec_en, req};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        unique case (paddr)
          OFS_DIV: prdata <= {16'h0000, div_q};
          OFS_PLL: prdata <= {16'h0000, pll_q};
          OFS_TUN: prdata <= {16'h0000, tun_q};
          OFS_OSC: prdata <= {16'h0000, osc_rd};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_q <= DIV_RST;                                  // [RL25]
      pll_q <= PLL_RST;                                  // [RL25]
      tun_q <= TUN_RST;                                  // [RL25]
    end else begin
      if (div_wr) div_q <= pwdata[15:0] & DIV_MASK;
      if (pll_wr) pll_q <= pwdata[15:0] & PLL_MASK;
      if (tun_wr) tun_q <= pwdata[15:0] & TUN_MASK;
      // Hardware recovery overrides a write in the same cycle
      if (div_q[ROI_B] && irq_event) div_q[CPU_SLOWDOWN_ENABLE_B] <= 1'b0; // [RL1]
    end
  end

  // Lockout is sticky; only a reset releases the clock source again
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      next_source_select    <= SRC_FRC;
      lockout <= 1'b0;
      sec_en  <= 1'b0;
    end else if (osc_wr) begin
      sec_en <= pwdata[SEC_B];
      if (!lockout) begin
        next_source_select    <= pwdata[NEXT_SOURCE_SELECT_LSB +: 3];                // [RL11]
        lockout <= pwdata[LKOUT_B] & sw_en & ~clock_fail_monitor_on;   // [RL24]
      end
    end
  end

  assign busy      = (st != ST_IDLE);
  assign fail_go   = clock_fail_monitor_on & fail_s & ~cf;
  assign src_ready = (!is_pll(tgt) || lock_stat) &&
                     (!is_pri(tgt) || primary_submode == PSM_EC || xtal_s); // [RL14]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st              <= ST_IDLE;
      cur             <= SRC_FRC;
      tgt             <= SRC_FRC;
      req             <= 1'b0;
      cf              <= 1'b0;
      lock_stat       <= 1'b0;
      cnt             <= 4'h0;
      clock_fail_trap <= 1'b0;
    end else begin
      clock_fail_trap <= 1'b0;
      if (lock_s) lock_stat <= 1'b1;
      if (osc_wr && !pwdata[CF_B]) cf <= 1'b0;
      if (osc_wr && pwdata[REQ_B] && sw_en && !lockout) req <= 1'b1;
      unique case (st)
        ST_IDLE: begin
          if (req && sw_en) begin
            if (next_source_select == cur) begin
              req <= 1'b0;                               // [RL12]
            end else begin
              tgt       <= next_source_select;
              st        <= ST_WAIT;                      // [RL14]
              lock_stat <= 1'b0;                         // [RL13]
              cf        <= 1'b0;                         // [RL13]
            end
          end
        end
        ST_WAIT: begin
          if (src_ready) begin
            st  <= ST_SETTLE;
            cnt <= 4'h0;
          end
        end
        ST_SETTLE: begin
          if (tick) begin
            if (cnt == SETTLE_CYC - 4'h1) begin          // [RL15]
              cur <= tgt;                                // [RL16]
              req <= 1'b0;                               // [RL16]
              st  <= ST_IDLE;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
      endcase
      // A failure beats a flag clear or a switch in the same cycle
      if (fail_go) begin
        cur             <= is_pll(cur) ? SRC_FAST_RC_WITH_MULTIPLIER : SRC_FRC; // [RL22]
        st              <= ST_IDLE;
        req             <= 1'b0;
        cf              <= 1'b1;
        clock_fail_trap <= 1'b1;                         // [RL22]
      end
      if (cfg_taken && !sw_en) begin
        cur <= strap_src;                                // [RL10]
        req <= 1'b0;                                     // [RL10]
        st  <= ST_IDLE;
      end
      if (cap_now) cur <= rsc_s;                         // [RL23]
    end
  end

  // Old source is dropped only when idle; both run while switching
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frc_on      <= 1'b1;
      pri_on      <= 1'b0;
      sec_on      <= 1'b0;
      low_power_rc_osc_on     <= 1'b0;
      pll_on      <= 1'b0;
      sys_src_sel <= SRC_FRC;
      switch_busy <= 1'b0;
    end else begin
      frc_on  <= is_frc(cur) | (busy & is_frc(tgt));     // [RL17]
      pri_on  <= is_pri(cur) | (busy & is_pri(tgt));     // [RL17]
      pll_on  <= is_pll(cur) | (busy & is_pll(tgt));
      sec_on  <= sec_en | (cur == SRC_SEC) | (busy & (tgt == SRC_SEC)); // [RL17]
      low_power_rc_osc_on <= (clock_fail_monitor_on & ~sleep_active) | watchdog_enable |
                 (cur == SRC_LOW_POWER_RC_OSC) | (busy & (tgt == SRC_LOW_POWER_RC_OSC)); // [RL21]
      sys_src_sel <= cur;
      switch_busy <= busy;
    end
  end

  // Ratio outputs never stall the processor, even mid-switch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_div_log2 <= 3'h0;
      frc_div_log2 <= 4'h0;
      pll_n1       <= 6'h02;
      pll_n2       <= 4'h4;
      pll_m        <= 10'h032;
      frc_trim     <= 6'h00;
    end else begin
      cpu_div_log2 <= div_q[CPU_SLOWDOWN_ENABLE_B] ? div_q[DOZE_LSB +: 3] : 3'h0; // [RL2] [RL3] [RL18]
      frc_div_log2 <= (div_q[FRCD_LSB +: 3] == 3'h7) ? 4'h8 :
                      {1'b0, div_q[FRCD_LSB +: 3]};      // [RL4]
      pll_n2   <= post_div(div_q[POST_LSB +: 2]);        // [RL5]
      pll_n1   <= {1'b0, div_q[PRE_LSB +: 5]} + 6'h02;   // [RL6]
      pll_m    <= {1'b0, pll_q[8:0]} + 10'h002;          // [RL7]
      frc_trim <= tun_q[5:0];                            // [RL8]
    end
  end

  a_roi_recover: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL1]
    (div_q[ROI_B] && irq_event) |=> !div_q[CPU_SLOWDOWN_ENABLE_B] ##1 (cpu_div_log2 == 3'h0))
    else $error("interrupt did not end slowdown");

  a_ratio_forced: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL3]
    !div_q[CPU_SLOWDOWN_ENABLE_B] |=> (cpu_div_log2 == 3'h0))
    else $error("ratio not forced to one");

  a_redundant_abort: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL12]
    (st == ST_IDLE && req && sw_en && next_source_select == cur && !fail_go) |=> !req && st == ST_IDLE)
    else $error("redundant switch not aborted");

  a_start_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL13]
    $rose(st == ST_WAIT)
    |-> !cf && !lock_stat)
    else $error("flags not cleared at switch start");

  a_settle_done: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL16]
    (st == ST_SETTLE && tick && cnt == SETTLE_CYC - 4'h1 && !fail_go && sw_en)
    |=> (cur == $past(tgt)) && !req ##1 (sys_src_sel == $past(tgt, 2)))
    else $error("switch completion wrong");

  a_settle_early: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL15]
    ($past(st) == ST_SETTLE && cur != $past(cur) && !$past(fail_go))
    |-> $past(tick) && ($past(cnt) == SETTLE_CYC - 4'h1))
    else $error("source changed before settle count");

  a_disabled_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL10]
    (cfg_taken && !sw_en) |=> !req && (cur == strap_src))
    else $error("switch active while disabled");

  a_fail_fallback: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL22]
    fail_go |=> clock_fail_trap && cf &&
      (cur == (is_pll($past(cur)) ? SRC_FAST_RC_WITH_MULTIPLIER : SRC_FRC)))
    else $error("fail fallback wrong");

  a_lockout_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL24]
    lockout |=> lockout && $stable(next_source_select))
    else $error("lockout released or next select changed");

  a_pll_mult: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL7]
    pll_wr ##2 1'b1 |-> (pll_m == {1'b0, $past(pwdata[8:0], 2)} + 10'h002))
    else $error("multiplier output wrong");
endmodule // ccu_top

// [testbench/ccu_osc_model.sv]
// Behavioural oscillators, PLL and new-source clock facing the clock control unit
`timescale 1ns/1ps
module ccu_osc_model #(
  parameter int LOCK_DLY = 20,
  parameter int OST_DLY  = 30
) (
  input  wire logic clk_sys,
  input  wire logic pri_on,
  input  wire logic pll_on,
  input  wire logic any_on,
  input  wire logic fail_cmd,
  output logic      crystal_timer_done,
  output logic      pll_lock,
  output logic      osc_fail,
  output logic      new_clk
);
  int lock_cnt;
  int ost_cnt;

  initial begin
    new_clk = 1'b0;
    lock_cnt = 0;
    ost_cnt = 0;
    crystal_timer_done = 1'b0;
    pll_lock = 1'b0;
  end

  // Lock and start-up timer come late on purpose, so a switch that skips the wait shows
  always @(posedge clk_sys) begin
    lock_cnt <= pll_on ? ((lock_cnt < LOCK_DLY) ? lock_cnt + 1 : lock_cnt) : 0;
    ost_cnt <= pri_on ? ((ost_cnt < OST_DLY) ? ost_cnt + 1 : ost_cnt) : 0;
    pll_lock <= pll_on && (lock_cnt == LOCK_DLY);
    crystal_timer_done <= pri_on && (ost_cnt == OST_DLY);
  end

  assign osc_fail = fail_cmd;

  // Slow source clock, still while every oscillator is off
  always #30 new_clk = any_on ? ~new_clk : new_clk;
endmodule // ccu_osc_model

// [testbench/testbench.sv]
// Self-checking bench of the clock control unit over APB
`timescale 1ns/1ps
module testbench;
  import ccu_pkg::*;
  logic        clk_sys, resetn, psel, penable, pwrite, irq_event, sleep_active;
  logic        switch_monitor_config, crystal_timer_done, pll_lock, osc_fail, new_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, fail_cmd, busy_seen;
  logic [2:0]  reset_source_config, cpu_div_log2, sys_src_sel;
  logic [3:0]  frc_div_log2, pll_n2;
  logic [5:0]  pll_n1, frc_trim;
  logic [9:0]  pll_m;
  logic [1:0]  primary_submode, primary_submode_config;
  logic        frc_on, pri_on, sec_on, low_power_rc_osc_on, pll_on, clock_fail_trap, switch_busy;
  logic        watchdog_enable, fail_monitor_off_config;
  int          n_mismatch, num_checks, trap_cnt;

  ccu_top uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_event, .watchdog_enable, .sleep_active,
    .switch_monitor_config, .fail_monitor_off_config, .reset_source_config,
    .primary_submode_config, .crystal_timer_done, .pll_lock, .osc_fail, .new_clk,
    .cpu_div_log2, .frc_div_log2, .pll_n1, .pll_n2, .pll_m, .frc_trim, .sys_src_sel,
    .primary_submode, .frc_on, .pri_on, .sec_on, .low_power_rc_osc_on, .pll_on, .clock_fail_trap,
    .switch_busy);

  ccu_osc_model osc (.clk_sys, .pri_on, .pll_on, .any_on(frc_on | pri_on | sec_on | low_power_rc_osc_on
    | pll_on), .fail_cmd, .crystal_timer_done, .pll_lock, .osc_fail, .new_clk);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (switch_busy === 1'b1) busy_seen <= 1'b1;
    if (clock_fail_trap === 1'b1) trap_cnt <= trap_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset(input logic sw, input logic [2:0] rs);
    @(posedge clk_sys);
    resetn <= 1'b0;
    switch_monitor_config <= sw;
    reset_source_config <= rs;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic pulse_irq;
    @(posedge clk_sys);
    irq_event <= 1'b1;
    @(posedge clk_sys);
    irq_event <= 1'b0;
    settle;
  endtask

  // Keeps the clock fail flag (bit 3 written as 1) so its hardware clear can be seen
  task automatic switch_to(input logic [2:0] s, input logic valid);
    int n;
    n = 0;
    busy_seen = 1'b0;
    apb(1'b1, OFS_OSC, {21'h0, s, 8'h08});
    apb(1'b1, OFS_OSC, {21'h0, s, 8'h09});
    do begin
      apb(1'b0, OFS_OSC, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    settle;
    chk("busy_seen", valid, busy_seen);
    chk("cur_src", s, rd[14:12]);
    chk("cf_cleared", 1'b0, rd[3]);
    chk("sys_src", s, sys_src_sel);
  endtask

  task automatic fail_event(input logic [2:0] e);
    trap_cnt = 0;
    @(posedge clk_sys);
    fail_cmd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fail_cmd <= 1'b0;
    settle;
    chk("trap_count", 1, trap_cnt);
    chk("fail_src", e, sys_src_sel);
    apb(1'b0, OFS_OSC, 32'h0);
    chk("cf_set", 1'b1, rd[3]);
    chk("fail_cur", e, rd[14:12]);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    final_report;
  end

  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, irq_event, sleep_active, fail_cmd, busy_seen} = 7'h0;
    {watchdog_enable, fail_monitor_off_config} = 2'h0;
    primary_submode_config = 2'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    switch_monitor_config = 1'b1;
    reset_source_config = 3'h5;
    n_mismatch = 0;
    num_checks = 0;
    trap_cnt = 0;
    do_reset(1'b1, 3'h5);
    rchk(OFS_DIV, 32'h3040, "div_reset");
    rchk(OFS_PLL, 32'h0030, "pll_reset");
    rchk(OFS_TUN, 32'h0000, "tun_reset");
    settle;
    chk("reset_ratio", 32'h0, cpu_div_log2);
    chk("reset_m", 32'd50, pll_m);
    chk("reset_n2", 32'd4, pll_n2);
    // Switching is off here: the request must not stick and the strap source shows
    apb(1'b1, OFS_OSC, 32'h0201);
    rchk(OFS_OSC, 32'h5200, "osc_off");
    settle;
    chk("off_src", 32'h5, sys_src_sel);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, OFS_DIV, 32'hffffffff);
    apb(1'b1, OFS_PLL, 32'hffffffff);
    apb(1'b1, OFS_TUN, 32'hffffffff);
    rchk(OFS_DIV, 32'hffdf, "div_mask");
    rchk(OFS_PLL, 32'h01ff, "pll_mask");
    rchk(OFS_TUN, 32'h003f, "tun_mask");
    settle;
    chk("m_max", 32'd513, pll_m);
    chk("n1_max", 32'd33, pll_n1);
    chk("trim_min1", 32'h3f, frc_trim);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_DIV, {16'h0, 1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 1'b0, i[4:0]});
      settle;
      chk("cpu_div", i, cpu_div_log2);
      chk("frc_div", (i == 7) ? 8 : i, frc_div_log2);
      chk("n2", (i[1:0] == 2'h0) ? 2 : ((i[1:0] == 2'h3) ? 8 : 4), pll_n2);
      chk("n1", i + 2, pll_n1);
    end
    apb(1'b1, OFS_TUN, 32'h20);
    settle;
    chk("trim_low", 32'h20, frc_trim);
    apb(1'b1, OFS_DIV, 32'hb800);
    pulse_irq;
    rchk(OFS_DIV, 32'hb000, "roi_clear");
    chk("roi_ratio", 32'h0, cpu_div_log2);
    apb(1'b1, OFS_DIV, 32'h3800);
    pulse_irq;
    rchk(OFS_DIV, 32'h3800, "roi_off");
    chk("roi_off_ratio", 32'h3, cpu_div_log2);
    // Switching and fail monitor on; fresh reset reloads every default
    do_reset(1'b0, 3'h0);
    rchk(OFS_DIV, 32'h3040, "div_rereset");
    settle;
    chk("low_power_rc_osc_held", 1'b1, low_power_rc_osc_on);
    chk("submode", 32'h0, primary_submode);
    @(posedge clk_sys);
    sleep_active <= 1'b1;
    settle;
    chk("low_power_rc_osc_sleep", 1'b0, low_power_rc_osc_on);
    @(posedge clk_sys);
    sleep_active <= 1'b0;
    switch_to(3'h0, 1'b0);
    switch_to(3'h2, 1'b1);
    chk("pri_running", 1'b1, pri_on);
    chk("frc_stopped", 1'b0, frc_on);
    fail_event(3'h0);
    switch_to(3'h1, 1'b1);
    chk("pll_running", 1'b1, pll_on);
    switch_to(3'h0, 1'b1);
    chk("pll_stopped", 1'b0, pll_on);
    switch_to(3'h3, 1'b1);
    fail_event(3'h1);
    apb(1'b1, OFS_OSC, 32'h030a);
    settle;
    chk("sec_held", 1'b1, sec_on);
    // Monitor off, crystal submode: watchdog hold, start-up timer wait and lockout
    @(posedge clk_sys);
    fail_monitor_off_config <= 1'b1;
    primary_submode_config <= 2'h1;
    watchdog_enable <= 1'b1;
    do_reset(1'b0, 3'h0);
    chk("submode_xt", 32'h1, primary_submode);
    chk("low_power_rc_osc_wdog", 1'b1, low_power_rc_osc_on);
    switch_to(3'h2, 1'b1);
    apb(1'b1, OFS_OSC, 32'h0280);
    apb(1'b1, OFS_OSC, 32'h0001);
    rchk(OFS_OSC, 32'h2280, "locked_out");
    settle;
    chk("locked_src", 32'h2, sys_src_sel);
    final_report;
  end
endmodule // testbench
